// File: inc/pic_pkg.sv
// Constants and types for the partial image compatibility checker.
// Assumes one configuration clock; image headers arrive as aligned 32-bit words.
package pic_pkg;

  localparam int unsigned WORD_W     = 32;
  localparam int unsigned OFFS_W     = 8;
  localparam int unsigned NUM_FIELDS = 4;

  // Header byte offsets of the identifier record, in record order.
  localparam logic [OFFS_W-1:0] OFFS_NODE   = 8'h18;
  localparam logic [OFFS_W-1:0] OFFS_HASH   = 8'h24;
  localparam logic [OFFS_W-1:0] OFFS_PARENT = 8'h28;
  localparam logic [OFFS_W-1:0] OFFS_FUNC   = 8'h2c;

  // Field slot positions in the capture vector.
  localparam int unsigned FLD_NODE   = 0;
  localparam int unsigned FLD_HASH   = 1;
  localparam int unsigned FLD_PARENT = 2;
  localparam int unsigned FLD_FUNC   = 3;

  // Node identifier values.
  localparam logic [WORD_W-1:0] NODE_STATIC_FABRIC = 32'h1870_0000;
  localparam logic [WORD_W-1:0] NODE_STAGE2        = 32'h1870_0001;
  localparam logic [WORD_W-1:0] NODE_FIRST_RM      = 32'h1870_0002;
  localparam logic [WORD_W-1:0] NODE_STATIC_ARRAY  = 32'h1880_0000;
  localparam logic [WORD_W-1:0] NODE_FABRIC_LIMIT  = 32'h1880_0000;

  // Parent of a static entry and default of the user function field.
  localparam logic [WORD_W-1:0] IDENT_ZERO = 32'h0000_0000;

  // Reset value of the stored hashes, and the mask for all fields seen.
  localparam logic [WORD_W-1:0]     UID_RST  = 32'h0000_0000;
  localparam logic [NUM_FIELDS-1:0] SEEN_ALL = 4'hf;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_HDR   = 4'b0010,
    ST_CHECK = 4'b0100,
    ST_PROG  = 4'b1000
  } pic_state_t;

endpackage : pic_pkg

// File: design/pic_field_grab.sv
// Captures the four identifier fields of one header record by byte offset.
// Assumes header words come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module pic_field_grab
  import pic_pkg::*;
#(
  parameter int unsigned W = 32
)(
  input  wire logic                  clk_in,
  input  wire logic                  rst_b_in,
  input  wire logic                  clear_in,
  input  wire logic                  word_valid_in,
  input  wire logic [OFFS_W-1:0]     word_offs_in,
  input  wire logic [W-1:0]          word_data_in,
  output logic      [NUM_FIELDS-1:0] seen_out,
  output logic      [W-1:0]          node_ident_field_out,
  output logic      [W-1:0]          module_hash_field_out,
  output logic      [W-1:0]          parent_ident_field_out,
  output logic      [W-1:0]          user_function_field_out
);

  localparam logic [OFFS_W-1:0] FIELD_OFFS [NUM_FIELDS] =
    '{OFFS_NODE, OFFS_HASH, OFFS_PARENT, OFFS_FUNC};

  logic [W-1:0]          field_q [NUM_FIELDS];
  logic [W-1:0]          field_d [NUM_FIELDS];
  logic [NUM_FIELDS-1:0] seen_q;
  logic [NUM_FIELDS-1:0] seen_d;

  genvar g;
  generate
    for (g = 0; g < NUM_FIELDS; g++)
    begin : g_field
      // A clear and a matching word in one cycle: the word starts the new record.
      always_comb
      begin
        field_d[g] = clear_in ? W'(0) : field_q[g];
        seen_d[g]  = clear_in ? 1'b0 : seen_q[g];
        if (word_valid_in && (word_offs_in == FIELD_OFFS[g]))
        begin
          field_d[g] = word_data_in;
          seen_d[g]  = 1'b1;
        end
      end

      always_ff @(posedge clk_in or negedge rst_b_in)
      begin
        if (!rst_b_in)
        begin
          field_q[g] <= '0;
          seen_q[g]  <= 1'b0;
        end
        else
        begin
          field_q[g] <= field_d[g];
          seen_q[g]  <= seen_d[g];
        end
      end
    end
  endgenerate

  assign seen_out                = seen_q;
  assign node_ident_field_out    = field_q[FLD_NODE];
  assign module_hash_field_out   = field_q[FLD_HASH];
  assign parent_ident_field_out  = field_q[FLD_PARENT];
  assign user_function_field_out = field_q[FLD_FUNC];

endmodule // pic_field_grab

`default_nettype wire

// File: design/pic_checker.sv
// Partial image compatibility checker: judges image headers by their identifier records.
// Assumes a delivery path on clk_in that programs data only while program_en_out is high.
// Overview of operation
// - Each record yields four 32-bit fields: node, hash, parent and function.
// - The node identifier comes from header byte offset 0x18.
// - The module hash comes from header byte offset 0x24.
// - The parent identifier comes from header byte offset 0x28.
// - The user function identifier comes from header byte offset 0x2c.
// - Nodes 0x18700000 and 0x18800000 are the fabric and array static images.
// - Module partitions carry node 0x18700002 upward, one per partition.
// - Node 0x18700001 is kept for the second stage of a two-stage power-up.
// - A static record always has a zero parent, which marks it as static.
// - A module's parent must equal the hash of its static design.
// - In two-stage mode the parent is compared with the second-stage hash.
// - The function field should be zero and never affects the decision.
// - A mismatched partial image is refused before any data is programmed.
// - Record fields are ordered node, hash, parent, function.
// - A full image holds the static record then module records; a partial only one.
`timescale 1ns/1ps
`default_nettype none

module pic_checker
#(
  parameter int unsigned W = pic_pkg::WORD_W
)(
  input  wire logic                      clk_in,
  input  wire logic                      rst_b_in,
  input  wire logic                      image_start_in,
  input  wire logic                      image_partial_in,
  input  wire logic                      two_stage_in,
  input  wire logic                      word_valid_in,
  input  wire logic [pic_pkg::OFFS_W-1:0] word_offs_in,
  input  wire logic [W-1:0]              word_data_in,
  input  wire logic                      record_end_in,
  input  wire logic                      header_end_in,
  input  wire logic                      load_done_in,
  input  wire logic                      load_fail_in,
  output logic                           accept_out,
  output logic                           reject_out,
  output logic                           program_en_out,
  output logic                           busy_out,
  output logic                           static_valid_out,
  output logic      [W-1:0]              image_identifier_out,
  output logic      [W-1:0]              stage2_identifier_out,
  output logic                           func_nonzero_out
);
  import pic_pkg::*;

  pic_state_t            state_q, state_d;
  logic                  partial_q, partial_d;
  logic                  first_rec_q, first_rec_d;
  logic                  static_seen_q, static_seen_d;
  logic                  have_static_q, have_static_d;
  logic                  have_stage2_q, have_stage2_d;
  logic [W-1:0]          uid_q, uid_d;
  logic [W-1:0]          stage2_q, stage2_d;
  logic [W-1:0]          pend_uid_q, pend_uid_d;
  logic [W-1:0]          pend_stage2_q, pend_stage2_d;
  logic                  pend_s2v_q, pend_s2v_d;
  logic                  accept_q, accept_d;
  logic                  reject_q, reject_d;
  logic                  func_nz_q, func_nz_d;
  logic                  prog_en_q, prog_en_d;
  logic                  busy_q, busy_d;
  logic                  grab_clear;
  logic [NUM_FIELDS-1:0] seen;
  logic [W-1:0]          node_ident_field;
  logic [W-1:0]          module_hash_field;
  logic [W-1:0]          parent_ident_field;
  logic [W-1:0]          user_function_field;
  logic                  node_is_static;
  logic                  node_is_module;
  logic [W-1:0]          expect_parent;
  logic                  expect_valid;
  logic                  partial_ok;

  pic_field_grab #(.W(W)) u_grab (
    .clk_in                  (clk_in),
    .rst_b_in                (rst_b_in),
    .clear_in                (grab_clear),
    .word_valid_in           (word_valid_in && (state_q == ST_HDR)),
    .word_offs_in            (word_offs_in),
    .word_data_in            (word_data_in),
    .seen_out                (seen),
    .node_ident_field_out    (node_ident_field),
    .module_hash_field_out   (module_hash_field),
    .parent_ident_field_out  (parent_ident_field),
    .user_function_field_out (user_function_field)
  );

  assign node_is_static = (node_ident_field == NODE_STATIC_FABRIC) ||
                          (node_ident_field == NODE_STATIC_ARRAY);
  // The stage-two node sits below the first module node, so it never passes.
  assign node_is_module = (node_ident_field >= NODE_FIRST_RM) &&
                          (node_ident_field < NODE_FABRIC_LIMIT);
  // Which stored hash a module must name as its parent.
  assign expect_parent = two_stage_in ? stage2_q : uid_q;
  assign expect_valid  = two_stage_in ? have_stage2_q : have_static_q;
  // Function field is left out of this decision on purpose.
  assign partial_ok = (seen == SEEN_ALL) && node_is_module && expect_valid &&
                      (parent_ident_field != IDENT_ZERO) &&
                      (parent_ident_field == expect_parent);

  assign grab_clear = (state_q == ST_IDLE) || (state_q == ST_CHECK);

  always_comb
  begin
    state_d       = state_q;
    partial_d     = partial_q;
    first_rec_d   = first_rec_q;
    static_seen_d = static_seen_q;
    have_static_d = have_static_q;
    have_stage2_d = have_stage2_q;
    uid_d         = uid_q;
    stage2_d      = stage2_q;
    pend_uid_d    = pend_uid_q;
    pend_stage2_d = pend_stage2_q;
    pend_s2v_d    = pend_s2v_q;
    accept_d      = 1'b0;
    reject_d      = 1'b0;
    func_nz_d     = func_nz_q;
    case (state_q)
      ST_IDLE:
        if (image_start_in)
        begin
          state_d       = ST_HDR;
          partial_d     = image_partial_in;
          first_rec_d   = 1'b1;
          static_seen_d = 1'b0;
          pend_s2v_d    = 1'b0;
          func_nz_d     = 1'b0;
        end
      ST_HDR:
        if (record_end_in)
          state_d = ST_CHECK;
        else if (header_end_in && !partial_q)
        begin
          // Full image done listing records; it needs its static record.
          accept_d = static_seen_q;
          reject_d = !static_seen_q;
          state_d  = static_seen_q ? ST_PROG : ST_IDLE;
        end
      ST_CHECK:
      begin
        first_rec_d = 1'b0;
        func_nz_d   = func_nz_q || (user_function_field != IDENT_ZERO);
        if (partial_q)
        begin
          // A partial holds exactly one record and is judged on it.
          accept_d = partial_ok;
          reject_d = !partial_ok;
          state_d  = partial_ok ? ST_PROG : ST_IDLE;
        end
        else if (first_rec_q)
        begin
          if ((seen == SEEN_ALL) && node_is_static &&
              (parent_ident_field == IDENT_ZERO))
          begin
            pend_uid_d    = module_hash_field;
            static_seen_d = 1'b1;
            state_d       = ST_HDR;
          end
          else
          begin
            reject_d = 1'b1;
            state_d  = ST_IDLE;
          end
        end
        else
        begin
          if (node_ident_field == NODE_STAGE2)
          begin
            pend_stage2_d = module_hash_field;
            pend_s2v_d    = 1'b1;
          end
          state_d = ST_HDR;
        end
      end
      ST_PROG:
        if (load_done_in)
        begin
          state_d = ST_IDLE;
          if (!partial_q)
          begin
            uid_d         = pend_uid_q;
            have_static_d = 1'b1;
            stage2_d      = pend_stage2_q;
            have_stage2_d = pend_s2v_q;
          end
        end
        else if (load_fail_in)
          state_d = ST_IDLE;
      default:
        state_d = ST_IDLE;
    endcase
    // Registered decodes of the next state keep these outputs glitch free.
    prog_en_d = (state_d == ST_PROG);
    busy_d    = (state_d != ST_IDLE);
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      state_q       <= ST_IDLE;
      partial_q     <= 1'b0;
      first_rec_q   <= 1'b0;
      static_seen_q <= 1'b0;
      have_static_q <= 1'b0;
      have_stage2_q <= 1'b0;
      uid_q         <= UID_RST;
      stage2_q      <= UID_RST;
      pend_uid_q    <= UID_RST;
      pend_stage2_q <= UID_RST;
      pend_s2v_q    <= 1'b0;
      accept_q      <= 1'b0;
      reject_q      <= 1'b0;
      func_nz_q     <= 1'b0;
      prog_en_q     <= 1'b0;
      busy_q        <= 1'b0;
    end
    else
    begin
      state_q       <= state_d;
      partial_q     <= partial_d;
      first_rec_q   <= first_rec_d;
      static_seen_q <= static_seen_d;
      have_static_q <= have_static_d;
      have_stage2_q <= have_stage2_d;
      uid_q         <= uid_d;
      stage2_q      <= stage2_d;
      pend_uid_q    <= pend_uid_d;
      pend_stage2_q <= pend_stage2_d;
      pend_s2v_q    <= pend_s2v_d;
      accept_q      <= accept_d;
      reject_q      <= reject_d;
      func_nz_q     <= func_nz_d;
      prog_en_q     <= prog_en_d;
      busy_q        <= busy_d;
    end
  end

  assign accept_out            = accept_q;
  assign reject_out            = reject_q;
  assign program_en_out        = prog_en_q;
  assign busy_out              = busy_q;
  assign static_valid_out      = have_static_q;
  assign image_identifier_out  = uid_q;
  assign stage2_identifier_out = stage2_q;
  assign func_nonzero_out      = func_nz_q;

  sequence s_part_check;
    (state_q == ST_CHECK) && partial_q;
  endsequence

  chk_good_partial_accepts: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    s_part_check and partial_ok |=> accept_out && program_en_out)
    else $error("Matching partial image was not accepted.");
  chk_bad_partial_rejects: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    s_part_check and !partial_ok |=> reject_out && !program_en_out)
    else $error("Mismatched partial image was not refused.");
  chk_no_prog_on_mismatch: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    $rose(program_en_out) |-> accept_out)
    else $error("Programming enabled without an acceptance.");
  chk_reject_keeps_uid: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    reject_out |-> $stable(image_identifier_out) && $stable(static_valid_out))
    else $error("Stored identifier moved on a refusal.");
  chk_stage2_compare: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    s_part_check and two_stage_in and (parent_ident_field != stage2_q) |=> reject_out)
    else $error("Two-stage parent not checked against stage two hash.");
  chk_static_zero_parent: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    (state_q == ST_CHECK) && !partial_q && first_rec_q &&
    (parent_ident_field != IDENT_ZERO) |=> reject_out ##1 !busy_out)
    else $error("Static record with nonzero parent not refused.");
  chk_full_load_stores: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    program_en_out && !partial_q && load_done_in |=>
      static_valid_out && (image_identifier_out == $past(pend_uid_q)))
    else $error("Full load did not store the static hash.");
  chk_reserved_node_refused: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    s_part_check and (node_ident_field == NODE_STAGE2) |=> reject_out)
    else $error("Reserved stage two node accepted as a partial.");
  chk_func_ignored: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    s_part_check and (user_function_field != IDENT_ZERO) and partial_ok
      |=> accept_out && func_nonzero_out)
    else $error("Function field changed the decision.");

endmodule // pic_checker

`default_nettype wire

// File: tb/pic_image_src.sv
// Model of the image delivery path that feeds header words to the checker.
// Assumes the checker samples its inputs on the rising edge of clk_in.
`timescale 1ns/1ps
`default_nettype none

module pic_image_src (
  input  wire logic                       clk_in,
  output logic                            start_out,
  output logic                            partial_out,
  output logic                            valid_out,
  output logic [pic_pkg::OFFS_W-1:0]      offs_out,
  output logic [pic_pkg::WORD_W-1:0]      data_out,
  output logic                            rec_end_out,
  output logic                            hdr_end_out,
  output logic                            done_out,
  output logic                            fail_out
);
  import pic_pkg::*;

  initial
  begin
    start_out   = 1'b0;
    partial_out = 1'b0;
    valid_out   = 1'b0;
    offs_out    = 8'h00;
    data_out    = 32'h0000_0000;
    rec_end_out = 1'b0;
    hdr_end_out = 1'b0;
    done_out    = 1'b0;
    fail_out    = 1'b0;
  end

  task automatic pulse_start(input logic part);
    start_out   = 1'b1;
    partial_out = part;
    @(posedge clk_in);
    #1;
    start_out = 1'b0;
  endtask

  // A cleared mask bit leaves that word out; the data lines never keep a stale word.
  task automatic send_record(input logic [WORD_W-1:0] node, hash, parent, func,
                             input logic [3:0] mask);
    logic [WORD_W-1:0] w [4];
    logic [OFFS_W-1:0] o [4];
    w = '{node, hash, parent, func};
    o = '{OFFS_NODE, OFFS_HASH, OFFS_PARENT, OFFS_FUNC};
    for (int i = 0; i < 4; i++)
    begin
      valid_out   = mask[i];
      offs_out    = o[i];
      data_out    = w[i];
      rec_end_out = (i == 3);
      @(posedge clk_in);
      #1;
    end
    valid_out   = 1'b0;
    rec_end_out = 1'b0;
    offs_out    = ~offs_out;
    data_out    = ~data_out;
  endtask

  task automatic pulse_hdr_end();
    hdr_end_out = 1'b1;
    @(posedge clk_in);
    #1;
    hdr_end_out = 1'b0;
  endtask

  task automatic pulse_load(input logic ok);
    done_out = ok;
    fail_out = !ok;
    @(posedge clk_in);
    #1;
    done_out = 1'b0;
    fail_out = 1'b0;
  endtask

endmodule // pic_image_src

`default_nettype wire

// File: tb/tb.sv
// Self-checking bench for the partial image compatibility checker.
// Assumes the delivery path model pic_image_src drives all image inputs.
`timescale 1ns/1ps
`default_nettype none

module tb;
  import pic_pkg::*;

  localparam logic [WORD_W-1:0] H1 = 32'h3c5a_0e11;
  localparam logic [WORD_W-1:0] H2 = 32'h7d21_44b0;
  localparam logic [WORD_W-1:0] H3 = 32'h0b9e_6a37;
  localparam logic [WORD_W-1:0] H4 = 32'h5512_c0de;

  logic              clk_in, rst_b_in, two_stage_in;
  logic              start, partial, valid, rec_end, hdr_end, done, fail;
  logic [OFFS_W-1:0] offs;
  logic [WORD_W-1:0] data, image_identifier, uid2, exp_uid;
  logic              acc, rej, prog, busy, sval, fnz;
  int                error_cnt, tests_run, cycles;

  pic_image_src src (.clk_in(clk_in), .start_out(start), .partial_out(partial),
    .valid_out(valid), .offs_out(offs), .data_out(data), .rec_end_out(rec_end),
    .hdr_end_out(hdr_end), .done_out(done), .fail_out(fail));

  pic_checker uut (.clk_in(clk_in), .rst_b_in(rst_b_in), .image_start_in(start),
    .image_partial_in(partial), .two_stage_in(two_stage_in), .word_valid_in(valid),
    .word_offs_in(offs), .word_data_in(data), .record_end_in(rec_end),
    .header_end_in(hdr_end), .load_done_in(done), .load_fail_in(fail),
    .accept_out(acc), .reject_out(rej), .program_en_out(prog), .busy_out(busy),
    .static_valid_out(sval), .image_identifier_out(image_identifier),
    .stage2_identifier_out(uid2), .func_nonzero_out(fnz));

  initial
  begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      error_cnt++;
      conclude();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  // Collects the one-cycle accept and reject pulses over a short window.
  task automatic verdict(output logic [1:0] got);
    got = 2'b00;
    repeat (5)
    begin
      if (acc === 1'b1) got[0] = 1'b1;
      if (rej === 1'b1) got[1] = 1'b1;
      @(posedge clk_in);
      #1;
    end
  endtask

  task automatic run_partial(input logic [WORD_W-1:0] node, parent, func,
                             input logic [3:0] mask, input logic ok);
    logic [1:0] got;
    src.pulse_start(1'b1);
    src.send_record(node, H4, parent, func, mask);
    verdict(got);
    check("verdict", got, ok ? 2'b01 : 2'b10);
    check("program_en", prog, ok);
    if (ok) check("func flag", fnz, func != 32'h0000_0000);
    if (ok) src.pulse_load(1'b1);
    wait_cyc(1);
    check("busy", busy, 1'b0);
    check("stored hash", image_identifier, exp_uid);
  endtask

  task automatic run_full(input logic [WORD_W-1:0] node0, hash0, parent0, node1, hash1,
                          input logic ok, input logic load_ok);
    logic [1:0] got;
    src.pulse_start(1'b0);
    src.send_record(node0, hash0, parent0, 32'h0000_0000, 4'hf);
    if (ok)
    begin
      wait_cyc(2);
      src.send_record(node1, hash1, hash0, 32'h0000_0000, 4'hf);
      wait_cyc(2);
      src.pulse_hdr_end();
    end
    verdict(got);
    check("full verdict", got, ok ? 2'b01 : 2'b10);
    check("full program_en", prog, ok);
    if (ok) src.pulse_load(load_ok);
    wait_cyc(1);
    if (ok && load_ok) exp_uid = hash0;
    check("stored hash", image_identifier, exp_uid);
    if (ok && load_ok && node1 == NODE_STAGE2) check("stage2 hash", uid2, hash1);
  endtask

  task automatic t_reset();
    check("busy", busy, 1'b0);
    check("static_valid", sval, 1'b0);
    check("stored hash", image_identifier, 32'h0000_0000);
    check("program_en", prog, 1'b0);
    $display("done t_reset");
  endtask

  task automatic t_no_static();
    run_partial(NODE_FIRST_RM, H1, 32'h0000_0000, 4'hf, 1'b0);
    $display("done t_no_static");
  endtask

  task automatic t_full_static();
    run_full(NODE_STATIC_FABRIC, H1, IDENT_ZERO, NODE_FIRST_RM, H4, 1'b1, 1'b1);
    check("static_valid", sval, 1'b1);
    $display("done t_full_static");
  endtask

  task automatic t_partials();
    run_partial(NODE_FIRST_RM, H1, 32'h0000_0000, 4'hf, 1'b1);
    run_partial(32'h1870_0007, H1, 32'h0000_00a5, 4'hf, 1'b1);
    run_partial(NODE_FIRST_RM, H2, 32'h0000_0000, 4'hf, 1'b0);
    run_partial(NODE_STAGE2, H1, 32'h0000_0000, 4'hf, 1'b0);
    run_partial(NODE_STATIC_FABRIC, H1, 32'h0000_0000, 4'hf, 1'b0);
    run_partial(NODE_FIRST_RM, IDENT_ZERO, 32'h0000_0000, 4'hf, 1'b0);
    run_partial(NODE_FIRST_RM, H1, 32'h0000_0000, 4'h7, 1'b0);
    $display("done t_partials");
  endtask

  task automatic t_full_bad();
    run_full(NODE_FIRST_RM, H2, IDENT_ZERO, NODE_FIRST_RM, H4, 1'b0, 1'b0);
    run_full(NODE_STATIC_FABRIC, H2, H1, NODE_FIRST_RM, H4, 1'b0, 1'b0);
    run_full(NODE_STATIC_ARRAY, H2, IDENT_ZERO, NODE_FIRST_RM, H4, 1'b1, 1'b0);
    run_partial(NODE_FIRST_RM, H1, 32'h0000_0000, 4'hf, 1'b1);
    $display("done t_full_bad");
  endtask

  task automatic t_two_stage();
    run_full(NODE_STATIC_FABRIC, H2, IDENT_ZERO, NODE_STAGE2, H3, 1'b1, 1'b1);
    two_stage_in = 1'b1;
    run_partial(NODE_FIRST_RM, H3, 32'h0000_0000, 4'hf, 1'b1);
    run_partial(NODE_FIRST_RM, H2, 32'h0000_0000, 4'hf, 1'b0);
    two_stage_in = 1'b0;
    run_partial(NODE_FIRST_RM, H2, 32'h0000_0000, 4'hf, 1'b1);
    $display("done t_two_stage");
  endtask

  // A reset in mid-run must drop the stored hashes, so a partial is refused again.
  task automatic t_mid_reset();
    rst_b_in = 1'b0;
    wait_cyc(2);
    rst_b_in = 1'b1;
    exp_uid  = 32'h0000_0000;
    check("static_valid", sval, 1'b0);
    check("stored hash", image_identifier, exp_uid);
    check("stage2 hash", uid2, 32'h0000_0000);
    check("busy", busy, 1'b0);
    run_partial(NODE_FIRST_RM, H2, 32'h0000_0000, 4'hf, 1'b0);
    $display("done t_mid_reset");
  endtask

  initial
  begin
    error_cnt    = 0;
    tests_run    = 0;
    cycles       = 0;
    exp_uid      = 32'h0000_0000;
    two_stage_in = 1'b0;
    rst_b_in     = 1'b0;
    repeat (8) @(posedge clk_in);
    #1;
    rst_b_in = 1'b1;
    t_reset();
    t_no_static();
    t_full_static();
    t_partials();
    t_full_bad();
    t_two_stage();
    t_mid_reset();
    conclude();
  end

endmodule // tb

`default_nettype wire
